// *** hw/srw_defines.vh ***
// constants for the system reset and supervision timer block
// assumes one 20 MHz clock and a plain strobe register port
// Operation
// - in level mode the reset output is held until the selected rails are all good, plus a further delay.
// - the release delay is 0 ms or a doubling series from 1 ms up to 32.8 s.
// - in level mode reset releases on good-on and asserts again on good-off, each after the common delay.
// - in pulse mode one reset pulse of 0.001 s to 32.256 s follows good-on and the delay.
// - the supervision timer uses a general input and a general output and may run alone or drive reset.
// - kick pin and expiry pin are optional; kick may come by command and expiry may go through reset.
// - after power-up the timer starts at once or waits 0 ms or 100 ms doubling up to 1638 s.
// - the timeout period is programmable from 0.001 s to 32.256 s.
// - on timeout the block asserts a separate expiry pin or makes a system-reset pulse, as configured.
// - once expired the timer stays expired until a pin toggle, a kick command or the timer being disabled.
// - a start time and a reset time are kept; the start time only delays the first timeout, and the reset time elapsing unkicked means the processor failed.
// - on failure the reset output is toggled with a fixed or a general-input tracking release delay.
`ifndef SRW_DEFINES_VH
`define SRW_DEFINES_VH

// ==========================================================
// timing
`define SRW_CLK_HZ 20000000
`define SRW_TICK_PERIOD_MS 1
`define SRW_TICK_CYC ((`SRW_CLK_HZ / 1000) * `SRW_TICK_PERIOD_MS)
`define SRW_INIT_UNIT_MS 100
`define SRW_INIT_UNIT_TICKS (`SRW_INIT_UNIT_MS / `SRW_TICK_PERIOD_MS)
`define SRW_MS_MIN 15'h0001
`define SRW_MS_MAX 15'h7e00
`define SRW_DLY_CODE_MAX 5'h10

// ==========================================================
// register offsets
`define SRW_REG_CTRL 8'h00
`define SRW_REG_RAIL_SEL 8'h04
`define SRW_REG_DELAY 8'h08
`define SRW_REG_PULSE_W 8'h0c
`define SRW_REG_WD_TIMEOUT 8'h10
`define SRW_REG_WD_INIT 8'h14
`define SRW_REG_KICK 8'h18
`define SRW_REG_STATUS 8'h1c
`define SRW_REG_IRQ_STATUS 8'h20
`define SRW_REG_IRQ_MASK 8'h24

// ==========================================================
// control fields
`define SRW_CTRL_RST_EN 0
`define SRW_CTRL_PULSE 1
`define SRW_CTRL_WD_EN 2
`define SRW_CTRL_WD_TO_RST 3
`define SRW_CTRL_EXP_PIN_EN 4
`define SRW_CTRL_KICK_PIN_EN 5
`define SRW_CTRL_TRACK 6
`define SRW_CTRL_W 7

// ==========================================================
// interrupt bits and reset values
`define SRW_IRQ_EXPIRED 0
`define SRW_IRQ_RELEASED 1
`define SRW_IRQ_WD_RESET 2
`define SRW_IRQ_W 3
`define SRW_RST_CTRL 7'h00
`define SRW_RST_RAIL_SEL 12'h000
`define SRW_RST_DELAY 5'h00
`define SRW_RST_PULSE_W 15'h0001
`define SRW_RST_WD_TIMEOUT 15'h0001
`define SRW_RST_WD_INIT 4'h0

`endif

// *** hw/srw_sync.v ***
// two-flop synchroniser for a bundle of level inputs
// assumes each bit is an independent slow level
`timescale 1ns/1ps
`default_nettype none
module srw_sync #(
   parameter WIDTH = 1
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire [WIDTH-1:0] d_i,
   output reg [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] meta;

   // ==========================================================
   // first stage feeds only the second
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         meta <= {WIDTH{1'b0}};
         q_o <= {WIDTH{1'b0}};
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // srw_sync
`default_nettype wire

// *** hw/srw_tick.v ***
// internal timebase: 1 ms tick and 100 ms tick
// assumes CYC_PER_MS cycles of clk_i make one millisecond
`timescale 1ns/1ps
`default_nettype none
`include "srw_defines.vh"
module srw_tick #(
   parameter CYC_PER_MS = `SRW_TICK_CYC
) (
   input wire clk_i,
   input wire arst_n_i,
   output reg ms_tick_o,
   output reg unit_tick_o
);
   // integer forms first, then cut on purpose to the counter widths
   localparam integer LAST_CYC_I = CYC_PER_MS - 1;
   localparam integer LAST_MS_I = `SRW_INIT_UNIT_TICKS - 1;
   localparam [14:0] LAST_CYC = LAST_CYC_I[14:0];
   localparam [6:0] LAST_MS = LAST_MS_I[6:0];
   reg [14:0] cyc;
   reg [6:0] ms;

   // ==========================================================
   // free running divider, both ticks one cycle wide
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cyc <= 15'h0000;
         ms <= 7'h00;
         ms_tick_o <= 1'b0;
         unit_tick_o <= 1'b0;
      end
      else
      begin
         ms_tick_o <= 1'b0;
         unit_tick_o <= 1'b0;
         if (cyc == LAST_CYC)
         begin
            cyc <= 15'h0000;
            ms_tick_o <= 1'b1;
            if (ms == LAST_MS)
            begin
               ms <= 7'h00;
               unit_tick_o <= 1'b1;
            end
            else
               ms <= ms + 7'h01;
         end
         else
            cyc <= cyc + 15'h0001;
      end
   end
endmodule // srw_tick
`default_nettype wire

// *** hw/srw_top.v ***
// system reset generator and supervision timer with register port
// assumes rail good levels and pins are asynchronous; host bus is on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "srw_defines.vh"
module srw_top #(
   parameter CYC_PER_MS = `SRW_TICK_CYC
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire [11:0] rail_good_i,
   input wire kick_i,
   input wire track_i,
   output reg sys_rst_n_o,
   output reg expiry_o,
   output reg irq_o
);
   // ==========================================================
   // states
   localparam [5:0] R_HOLD = 6'h01;
   localparam [5:0] R_DLY = 6'h02;
   localparam [5:0] R_PULSE = 6'h04;
   localparam [5:0] R_RUN = 6'h08;
   localparam [5:0] R_OFFDLY = 6'h10;
   localparam [5:0] R_WDRST = 6'h20;
   localparam [3:0] W_OFF = 4'h1;
   localparam [3:0] W_INIT = 4'h2;
   localparam [3:0] W_RUN = 4'h4;
   localparam [3:0] W_EXP = 4'h8;

   // ==========================================================
   // functions
   function [15:0] dly_ms;
      input [4:0] code;
      begin
         if (code == 5'h00)
            dly_ms = 16'h0000;
         else if (code > `SRW_DLY_CODE_MAX)
            dly_ms = 16'h8000;
         else
            dly_ms = 16'h0001 << (code - 5'h01);
      end
   endfunction

   function [15:0] clamp_ms;
      input [14:0] v;
      begin
         if (v < `SRW_MS_MIN)
            clamp_ms = {1'b0, `SRW_MS_MIN};
         else if (v > `SRW_MS_MAX)
            clamp_ms = {1'b0, `SRW_MS_MAX};
         else
            clamp_ms = {1'b0, v};
      end
   endfunction

   function [15:0] init_units;
      input [3:0] code;
      begin
         if (code == 4'h0)
            init_units = 16'h0000;
         else
            init_units = 16'h0001 << (code - 4'h1);
      end
   endfunction

   // ==========================================================
   // timebase and input synchronisers
   wire ms_tick;
   wire unit_tick;
   wire [13:0] sync_q;

   srw_tick #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_tick (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ms_tick_o(ms_tick),
      .unit_tick_o(unit_tick)
   );

   srw_sync #(
      .WIDTH(14)
   ) u_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .d_i({track_i, kick_i, rail_good_i}),
      .q_o(sync_q)
   );

   wire [11:0] rail_s = sync_q[11:0];
   wire kick_s = sync_q[12];
   wire track_s = sync_q[13];

   // ==========================================================
   // configuration registers
   reg [`SRW_CTRL_W-1:0] ctrl;
   reg [11:0] rail_sel;
   reg [4:0] dly_code;
   reg [14:0] pulse_w;
   reg [14:0] wd_to;
   reg [3:0] init_code;
   reg [`SRW_IRQ_W-1:0] irq_st;
   reg [`SRW_IRQ_W-1:0] irq_mask;

   wire pulse_mode = ctrl[`SRW_CTRL_PULSE];
   // empty selection never counts as good, so reset cannot release by accident
   wire good = (rail_sel != 12'h000) && ((rail_s & rail_sel) == rail_sel);
   wire [15:0] dly_val = dly_ms(dly_code);

   // ==========================================================
   // kick detection
   reg kick_q;
   wire kick_cmd = wr_i && (addr_i == `SRW_REG_KICK);
   // either edge of the pin counts as a toggle
   wire kick_pin = ctrl[`SRW_CTRL_KICK_PIN_EN] && (kick_s != kick_q);
   wire kick = kick_pin || kick_cmd;

   // ==========================================================
   // supervision timer
   reg [3:0] wstate;
   reg [3:0] next_wstate;
   reg [15:0] wcnt;
   reg [15:0] next_wcnt;
   reg init_done;
   reg next_init_done;
   reg wd_fire;

   always @*
   begin
      next_wstate = wstate;
      next_wcnt = wcnt;
      next_init_done = init_done;
      wd_fire = 1'b0;
      case (wstate)
         W_OFF:
         begin
            if (ctrl[`SRW_CTRL_WD_EN])
            begin
               next_init_done = 1'b1;
               if (!init_done && (init_code != 4'h0))
               begin
                  next_wstate = W_INIT;
                  next_wcnt = init_units(init_code);
               end
               else
               begin
                  next_wstate = W_RUN;
                  next_wcnt = clamp_ms(wd_to);
               end
            end
         end
         W_INIT:
         begin
            if (kick || (wcnt == 16'h0000))
            begin
               next_wstate = W_RUN;
               next_wcnt = clamp_ms(wd_to);
            end
            else if (unit_tick)
               next_wcnt = wcnt - 16'h0001;
         end
         W_RUN:
         begin
            if (kick)
               next_wcnt = clamp_ms(wd_to);
            else if (wcnt == 16'h0000)
            begin
               next_wstate = W_EXP;
               wd_fire = 1'b1;
            end
            else if (ms_tick)
               next_wcnt = wcnt - 16'h0001;
         end
         W_EXP:
         begin
            if (kick)
            begin
               next_wstate = W_RUN;
               next_wcnt = clamp_ms(wd_to);
            end
         end
         default:
         begin
            next_wstate = W_OFF;
            next_wcnt = 16'h0000;
         end
      endcase
      if (!ctrl[`SRW_CTRL_WD_EN])
      begin
         next_wstate = W_OFF;
         wd_fire = 1'b0;
      end
   end

   // ==========================================================
   // system reset sequencer
   reg [5:0] rstate;
   reg [5:0] next_rstate;
   reg [15:0] rcnt;
   reg [15:0] next_rcnt;
   reg rst_act;
   wire wd_to_rst = wd_fire && ctrl[`SRW_CTRL_WD_TO_RST];

   always @*
   begin
      next_rstate = rstate;
      next_rcnt = rcnt;
      case (rstate)
         R_HOLD:
         begin
            if (ctrl[`SRW_CTRL_RST_EN] && good)
            begin
               next_rstate = R_DLY;
               next_rcnt = dly_val;
            end
         end
         R_DLY:
         begin
            if (!good)
               next_rstate = R_HOLD;
            else if (rcnt == 16'h0000)
            begin
               if (pulse_mode)
               begin
                  next_rstate = R_PULSE;
                  next_rcnt = clamp_ms(pulse_w);
               end
               else
                  next_rstate = R_RUN;
            end
            else if (ms_tick)
               next_rcnt = rcnt - 16'h0001;
         end
         R_PULSE:
         begin
            if (rcnt == 16'h0000)
               next_rstate = R_RUN;
            else if (ms_tick)
               next_rcnt = rcnt - 16'h0001;
         end
         R_RUN:
         begin
            if (wd_to_rst)
            begin
               next_rstate = R_WDRST;
               next_rcnt = dly_val;
            end
            else if (!good && !pulse_mode)
            begin
               next_rstate = R_OFFDLY;
               next_rcnt = dly_val;
            end
            else if (!good)
               next_rstate = R_HOLD;
         end
         R_OFFDLY:
         begin
            if (good)
               next_rstate = R_RUN;
            else if (rcnt == 16'h0000)
               next_rstate = R_HOLD;
            else if (ms_tick)
               next_rcnt = rcnt - 16'h0001;
         end
         R_WDRST:
         begin
            // tracking mode holds the count until the general input is high
            if (!ctrl[`SRW_CTRL_TRACK] || track_s)
            begin
               if (rcnt == 16'h0000)
                  next_rstate = R_RUN;
               else if (ms_tick)
                  next_rcnt = rcnt - 16'h0001;
            end
         end
         default:
         begin
            next_rstate = R_HOLD;
            next_rcnt = 16'h0000;
         end
      endcase
   end

   always @*
   begin
      rst_act = (next_rstate == R_PULSE) || (next_rstate == R_WDRST) ||
         (!pulse_mode && ((next_rstate == R_HOLD) || (next_rstate == R_DLY)));
   end

   // ==========================================================
   // interrupt status, set wins over clear
   wire w1c = wr_i && (addr_i == `SRW_REG_IRQ_STATUS);
   wire [`SRW_IRQ_W-1:0] irq_evt;
   reg [`SRW_IRQ_W-1:0] next_irq_st;
   assign irq_evt[`SRW_IRQ_EXPIRED] = wd_fire;
   assign irq_evt[`SRW_IRQ_RELEASED] = !sys_rst_n_o && !rst_act;
   assign irq_evt[`SRW_IRQ_WD_RESET] = wd_to_rst;

   always @*
   begin
      next_irq_st = irq_st;
      if (w1c)
         next_irq_st = irq_st & ~wdata_i[`SRW_IRQ_W-1:0];
      next_irq_st = next_irq_st | irq_evt;
   end

   // ==========================================================
   // state registers and outputs
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wstate <= W_OFF;
         wcnt <= 16'h0000;
         init_done <= 1'b0;
         rstate <= R_HOLD;
         rcnt <= 16'h0000;
         kick_q <= 1'b0;
         irq_st <= {`SRW_IRQ_W{1'b0}};
         sys_rst_n_o <= 1'b0;
         expiry_o <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         wstate <= next_wstate;
         wcnt <= next_wcnt;
         init_done <= next_init_done;
         rstate <= next_rstate;
         rcnt <= next_rcnt;
         kick_q <= kick_s;
         irq_st <= next_irq_st;
         sys_rst_n_o <= !rst_act;
         // expiry pin stays low when expiry is routed only through reset
         expiry_o <= (next_wstate == W_EXP) && ctrl[`SRW_CTRL_EXP_PIN_EN];
         irq_o <= |(next_irq_st & irq_mask);
      end
   end

   // ==========================================================
   // register writes
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl <= `SRW_RST_CTRL;
         rail_sel <= `SRW_RST_RAIL_SEL;
         dly_code <= `SRW_RST_DELAY;
         pulse_w <= `SRW_RST_PULSE_W;
         wd_to <= `SRW_RST_WD_TIMEOUT;
         init_code <= `SRW_RST_WD_INIT;
         irq_mask <= {`SRW_IRQ_W{1'b0}};
      end
      else if (wr_i)
      begin
         case (addr_i)
            `SRW_REG_CTRL: ctrl <= wdata_i[`SRW_CTRL_W-1:0];
            `SRW_REG_RAIL_SEL: rail_sel <= wdata_i[11:0];
            `SRW_REG_DELAY: dly_code <= wdata_i[4:0];
            `SRW_REG_PULSE_W: pulse_w <= wdata_i[14:0];
            `SRW_REG_WD_TIMEOUT: wd_to <= wdata_i[14:0];
            `SRW_REG_WD_INIT: init_code <= wdata_i[3:0];
            `SRW_REG_IRQ_MASK: irq_mask <= wdata_i[`SRW_IRQ_W-1:0];
            default: irq_mask <= irq_mask;
         endcase
      end
   end

   // ==========================================================
   // register reads, data valid only in the cycle after the strobe
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rdata_o <= 32'h00000000;
      else if (!rd_i)
         rdata_o <= 32'h00000000;
      else
      begin
         case (addr_i)
            `SRW_REG_CTRL: rdata_o <= {25'h0000000, ctrl};
            `SRW_REG_RAIL_SEL: rdata_o <= {20'h00000, rail_sel};
            `SRW_REG_DELAY: rdata_o <= {27'h0000000, dly_code};
            `SRW_REG_PULSE_W: rdata_o <= {17'h00000, pulse_w};
            `SRW_REG_WD_TIMEOUT: rdata_o <= {17'h00000, wd_to};
            `SRW_REG_WD_INIT: rdata_o <= {28'h0000000, init_code};
            `SRW_REG_STATUS: rdata_o <= {28'h0000000, good, (wstate == W_INIT),
               (wstate == W_EXP), !sys_rst_n_o};
            `SRW_REG_IRQ_STATUS: rdata_o <= {29'h00000000, irq_st};
            `SRW_REG_IRQ_MASK: rdata_o <= {29'h00000000, irq_mask};
            default: rdata_o <= 32'h00000000;
         endcase
      end
   end
endmodule // srw_top
`default_nettype wire

// *** tb/srw_chk.sv ***
// checker for the system reset and supervision timer top
// assumes it is bound onto srw_top and snoops the register writes it needs
`timescale 1ns/1ps
`default_nettype none
`include "srw_defines.vh"
module srw_chk #(
   parameter CYC_PER_MS = 20
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire [11:0] rail_good_i,
   input wire kick_i,
   input wire track_i,
   input wire sys_rst_n_o,
   input wire expiry_o,
   input wire irq_o
);
   // ==========================================================
   // snooped config, only what the properties need
   reg [6:0] ctrl;
   reg [11:0] sel;
   reg [2:0] mask;
   reg [3:0] gate_off_n;
   reg [3:0] rst_off_n;
   reg [3:0] quiet_n;
   reg kick_d;
   wire good = (sel != 12'h000) && ((rail_good_i & sel) == sel);
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl <= 7'h00;
         sel <= 12'h000;
         mask <= 3'h0;
         gate_off_n <= 4'hf;
         rst_off_n <= 4'hf;
         quiet_n <= 4'hf;
         kick_d <= 1'b0;
      end
      else
      begin
         if (wr_i && addr_i == `SRW_REG_CTRL) ctrl <= wdata_i[6:0];
         if (wr_i && addr_i == `SRW_REG_RAIL_SEL) sel <= wdata_i[11:0];
         if (wr_i && addr_i == `SRW_REG_IRQ_MASK) mask <= wdata_i[2:0];
         kick_d <= kick_i;
         // saturating counts, so long idle stretches never wrap
         gate_off_n <= (ctrl[2] && ctrl[4]) ? 4'h0 : gate_off_n + {3'h0, gate_off_n != 4'hf};
         rst_off_n <= ctrl[0] ? 4'h0 : rst_off_n + {3'h0, rst_off_n != 4'hf};
         quiet_n <= (wr_i || (ctrl[5] && kick_i != kick_d)) ? 4'h0 :
            quiet_n + {3'h0, quiet_n != 4'hf};
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside a read answer");
   status_bit_a: assert property (rd_i && addr_i == `SRW_REG_STATUS |=>
      rdata_o[0] == !$past(sys_rst_n_o) && rdata_o[31:4] == 28'h0)
      else $error("status read does not match reset output");
   unmapped_read_a: assert property (rd_i && addr_i == 8'hfc |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   hold_off_a: assert property (rst_off_n >= 4'h3 |-> !sys_rst_n_o)
      else $error("reset released while reset output disabled");
   release_good_a: assert property ($rose(sys_rst_n_o) && !ctrl[1] |-> $past(good, 5))
      else $error("reset released without selected rails good");
   expiry_gate_a: assert property (gate_off_n >= 4'h3 |-> !expiry_o)
      else $error("expiry pin high while not configured");
   expiry_sticky_a: assert property ($fell(expiry_o) |-> quiet_n < 4'ha)
      else $error("expiry cleared without a kick");
   irq_mask_a: assert property (mask == 3'h0 && $past(mask) == 3'h0 |-> !irq_o)
      else $error("interrupt high with all sources masked");
   cover property ($rose(expiry_o));
   cover property ($rose(sys_rst_n_o));
   cover property ($rose(irq_o));
   cover property (ctrl[6] && !sys_rst_n_o && $rose(track_i));
endmodule // srw_chk
bind srw_top srw_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .rail_good_i(rail_good_i), .kick_i(kick_i), .track_i(track_i), .sys_rst_n_o(sys_rst_n_o),
   .expiry_o(expiry_o), .irq_o(irq_o));
`default_nettype wire

// *** tb/srw_host.sv ***
// host-side partner: toggles the kick pin at a set spacing
// assumes the bench enables it and gives the spacing in cycles
`timescale 1ns/1ps
`default_nettype none
module srw_host (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic run_i,
   input wire logic [15:0] gap_i,
   output logic kick_o
);
   // ==========================================================
   // kick pacing, a wide gap models a slow host
   logic [15:0] cnt;
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt <= 16'h0000;
         kick_o <= 1'b0;
      end
      else if (run_i && cnt >= gap_i)
      begin
         cnt <= 16'h0000;
         kick_o <= !kick_o;
      end
      else
         cnt <= cnt + 16'h0001;
   end
endmodule // srw_host
`default_nettype wire

// *** tb/srw_tb_top.sv ***
// bench for the system reset and supervision timer top
// assumes srw_defines.vh on the include path; one ms is 20 cycles here
`timescale 1ns/1ps
`default_nettype none
`include "srw_defines.vh"
module srw_tb_top;
   localparam int MS = 20;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [11:0] rail_good_i = 12'h000;
   logic track_i = 1'b0;
   logic host_run = 1'b0;
   wire [31:0] rdata_o;
   wire kick_i, sys_rst_n_o, expiry_o, irq_o;
   int bad_count = 0;
   int samples_checked = 0;
   logic [31:0] rv;
   int n;
   logic [7:0] ra [0:9] = '{`SRW_REG_CTRL, `SRW_REG_RAIL_SEL, `SRW_REG_DELAY,
      `SRW_REG_PULSE_W, `SRW_REG_WD_TIMEOUT, `SRW_REG_WD_INIT, `SRW_REG_STATUS,
      `SRW_REG_IRQ_STATUS, `SRW_REG_IRQ_MASK, 8'hfc};
   logic [31:0] rx [0:9] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
   srw_top #(.CYC_PER_MS(MS)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rail_good_i(rail_good_i),
      .kick_i(kick_i), .track_i(track_i), .sys_rst_n_o(sys_rst_n_o), .expiry_o(expiry_o),
      .irq_o(irq_o));
   srw_host host (.clk_i(clk_i), .arst_n_i(arst_n_i), .run_i(host_run), .gap_i(16'h0014),
      .kick_o(kick_i));
   // ==========================================================
   // helpers
   task automatic give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // range check; a miss shows the low bound as expected
   task automatic rng(input int v, input int lo, input int hi);
      chk(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
   endtask
   // one idle edge after each strobe keeps strobes single-driven per step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      d = rdata_o;
   endtask
   function automatic logic sig(input int w);
      return (w == 0) ? sys_rst_n_o : (w == 1) ? expiry_o : irq_o;
   endfunction
   task automatic wt(input int w, input logic lvl, input int max, output int c);
      c = 0;
      while (sig(w) !== lvl)
      begin
         if (c >= max)
         begin
            bad_count++;
            give_verdict();
         end
         @(posedge clk_i);
         c++;
      end
   endtask
   task automatic stay(input int w, input logic lvl, input int cyc);
      int miss;
      miss = 0;
      repeat (cyc)
      begin
         @(posedge clk_i);
         if (sig(w) !== lvl) miss++;
      end
      chk(32'(miss), 32'h0);
   endtask
   // ==========================================================
   // clock and sequence
   initial
   begin
      forever #25 clk_i = !clk_i;
   end
   initial
   begin
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 10; i++)
      begin
         rd(ra[i], rv);
         chk(rv, rx[i]);
      end
      wr(`SRW_REG_RAIL_SEL, 32'h3);
      wr(`SRW_REG_DELAY, 32'h3);
      rail_good_i <= 12'h001;
      wr(`SRW_REG_CTRL, 32'h1);
      stay(0, 1'b0, 200);
      rail_good_i <= 12'h003;
      wt(0, 1'b1, 200, n);
      rng(n, 3 * MS, 4 * MS + 8);
      rail_good_i <= 12'h001;
      wt(0, 1'b0, 200, n);
      rng(n, 3 * MS, 4 * MS + 8);
      wr(`SRW_REG_DELAY, 32'h0);
      wr(`SRW_REG_PULSE_W, 32'h2);
      wr(`SRW_REG_CTRL, 32'h3);
      wt(0, 1'b1, 20, n);
      rail_good_i <= 12'h003;
      wt(0, 1'b0, 20, n);
      wt(0, 1'b1, 100, n);
      rng(n, MS, 2 * MS + 4);
      stay(0, 1'b1, 100);
      wr(`SRW_REG_CTRL, 32'h1);
      wt(0, 1'b1, 20, n);
      wr(`SRW_REG_WD_TIMEOUT, 32'h3);
      wr(`SRW_REG_WD_INIT, 32'h1);
      wr(`SRW_REG_CTRL, 32'h15);
      rd(`SRW_REG_STATUS, rv);
      chk(rv & 32'h4, 32'h4);
      wt(1, 1'b1, 105 * MS, n);
      rng(n, 2 * MS, 105 * MS);
      wr(`SRW_REG_CTRL, 32'h1);
      wt(1, 1'b0, 4, n);
      wr(`SRW_REG_CTRL, 32'h15);
      wt(1, 1'b1, 4 * MS, n);
      rng(n, 2 * MS - 2, 3 * MS + 4);
      rd(`SRW_REG_STATUS, rv);
      chk(rv & 32'h6, 32'h2);
      host_run <= 1'b1;
      stay(1, 1'b1, 200);
      wr(`SRW_REG_CTRL, 32'h35);
      wt(1, 1'b0, 40, n);
      stay(1, 1'b0, 300);
      host_run <= 1'b0;
      wt(1, 1'b1, 5 * MS, n);
      rng(n, MS, 3 * MS + 8);
      wr(`SRW_REG_KICK, 32'h0);
      wt(1, 1'b0, 6, n);
      repeat (8)
      begin
         repeat (25) @(posedge clk_i);
         wr(`SRW_REG_KICK, 32'h0);
         chk(32'(expiry_o), 32'h0);
      end
      wr(`SRW_REG_DELAY, 32'h2);
      wr(`SRW_REG_CTRL, 32'h5d);
      wt(1, 1'b1, 4 * MS, n);
      wt(0, 1'b0, 6, n);
      stay(0, 1'b0, 200);
      track_i <= 1'b1;
      wt(0, 1'b1, 3 * MS, n);
      rng(n, MS, 2 * MS + 8);
      stay(0, 1'b1, 100);
      rd(`SRW_REG_IRQ_STATUS, rv);
      chk(rv, 32'h7);
      wr(`SRW_REG_IRQ_MASK, 32'h4);
      wt(2, 1'b1, 4, n);
      wr(`SRW_REG_IRQ_MASK, 32'h0);
      wt(2, 1'b0, 4, n);
      wr(`SRW_REG_IRQ_MASK, 32'h7);
      wr(`SRW_REG_IRQ_STATUS, 32'h7);
      wt(2, 1'b0, 4, n);
      rd(`SRW_REG_IRQ_STATUS, rv);
      chk(rv, 32'h0);
      give_verdict();
   end
endmodule // srw_tb_top
`default_nettype wire
